// file: swj_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "swj_defs.svh"
// Function
// R1: Route to one of three access ports.
// R2: First core debug only via own port.
// R3: Second core debug only via own port.
// R4: Only system port reaches ROM table.
// R5: Each port gated by own bit pair.
// R6: Enable bits read/write, reset zero.
// R7: Disable bits sticky until next reset.
// R8: Disable bit overrides enable bit.
// R9: Watcher stays alive in deep sleep.
// R10: Host sets both power requests first.
// R11: Host keeps power requests set throughout.
// R12: Deep sleep: serial wire only, no JTAG.
// R13: Watcher picks one protocol from patterns.
// R14: JTAG active after power-up reset.
// R15: Switch only from current reset state.
// R16: Host sends highs, 0x79E7, highs.
// R17: JTAG detects pattern only from reset.
// R18: Host sends highs, 0x3CE7, highs.
// R19: Serial wire detects only in line reset.
// R20: Five highs bring TAP to reset.
// R21: Debug access acts as bus master.
// R22: Selected protocol holds until next switch.
module swj_device (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] ap_sel_i,
	input wire logic active_mode_i,
	output swj_pkg::swj_ap_t ap_grant_o,
	output logic rom_table_sel_o,
	output logic jtag_active_o,
	output logic swd_active_o,
	output logic power_up_req_o,
	output logic bus_master_en_o,
	swj_link_if.device link
);
	import swj_pkg::*;
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic clk_d_reg;
	logic rise;
	logic dm;
	logic pwr_ok;
	swj_mode_e mode_reg;
	logic tap_rst_reg;
	logic [5:0] high_reg;
	logic [15:0] hist_reg;
	logic [15:0] rst_hist_reg;
	logic [15:0] hist_next;
	logic [15:0] rst_hist_next;
	logic line_rst;
	logic in_reset;
	logic to_swd;
	logic to_jtag;
	swj_ap_t en_reg;
	swj_ap_t dis_reg;
	swj_ap_t open_ap;
	swj_ap_t sel_hot;
	logic acc;
	logic wr_ctrl;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			clk_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {link.system_power_request,
				link.debug_power_request, link.debug_data_mode_pin,
				link.debug_clock_pin};
			sync2_reg <= sync1_reg;
			clk_d_reg <= sync2_reg[0];
		end
	end
	assign rise = sync2_reg[0] && !clk_d_reg;
	assign dm = sync2_reg[1];
	assign pwr_ok = sync2_reg[2] && sync2_reg[3]; // see R10 see R11
	assign line_rst = high_reg >= 6'(`SWJ_LINE_RESET_HIGH);
	// The reset state seen before each bit is kept alongside the bit, so
	// the state ahead of a pattern's first bit is still known at its end.
	assign in_reset = (mode_reg == SWJ_MODE_JTAG) ? tap_rst_reg :
		line_rst; // see R15
	assign hist_next = {hist_reg[14:0], dm};
	assign rst_hist_next = {rst_hist_reg[14:0], in_reset};
	assign to_swd = mode_reg == SWJ_MODE_JTAG && rst_hist_next[15] &&
		hist_next == `SWJ_PAT_TO_SWD; // see R13 see R17
	assign to_jtag = mode_reg == SWJ_MODE_SWD && rst_hist_next[15] &&
		hist_next == `SWJ_PAT_TO_JTAG; // see R13 see R19
	// The watcher runs on the debug clock alone, in any power state.
	always_ff @(posedge clk_i) begin // see R9
		if (rst_i) begin
			mode_reg <= SWJ_MODE_JTAG; // see R14
			tap_rst_reg <= 1'b1; // see R14
			high_reg <= 6'h00;
			hist_reg <= 16'hFFFF;
			rst_hist_reg <= 16'h0000;
		end else if (rise) begin
			hist_reg <= hist_next;
			rst_hist_reg <= rst_hist_next;
			high_reg <= !dm ? 6'h00 :
				(high_reg == 6'h3F ? high_reg : high_reg + 6'h01);
			// TMS high five times lands in test-logic-reset from any state.
			tap_rst_reg <= dm && (tap_rst_reg || to_jtag ||
				high_reg >= 6'(`SWJ_TAP_RESET_HIGH - 1)); // see R20
			if (to_swd) begin
				mode_reg <= SWJ_MODE_SWD; // see R22
			end else if (to_jtag) begin
				mode_reg <= SWJ_MODE_JTAG; // see R22
			end
		end
	end
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctrl = acc && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == `SWJ_OFF_CTRL;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_reg <= 3'h0; // see R6
			dis_reg <= 3'h0;
		end else if (wr_ctrl) begin
			en_reg <= wb_dat_i[`SWJ_GATE_EN_LSB +: 3]; // see R5 see R6
			// Disable bits only ever set; only reset clears them.
			dis_reg <= dis_reg | wb_dat_i[`SWJ_GATE_DIS_LSB +: 3]; // see R7
		end
	end
	assign open_ap = en_reg & ~dis_reg; // see R5 see R8
	// Bit 0 first core, bit 1 second core, bit 2 system port.
	assign sel_hot = (ap_sel_i == 2'h0) ? 3'h1 :
		(ap_sel_i == 2'h1) ? 3'h2 : (ap_sel_i == 2'h2) ? 3'h4 : 3'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ap_grant_o <= 3'h0;
			rom_table_sel_o <= 1'b0;
			jtag_active_o <= 1'b0;
			swd_active_o <= 1'b0;
			power_up_req_o <= 1'b0;
			bus_master_en_o <= 1'b0;
		end else begin
			// One-hot grant keeps each core's debug path private.
			ap_grant_o <= pwr_ok ? (sel_hot & open_ap) :
				3'h0; // see R1 see R2 see R3
			rom_table_sel_o <= pwr_ok && sel_hot[2] && open_ap[2]; // see R4
			jtag_active_o <= mode_reg == SWJ_MODE_JTAG &&
				active_mode_i; // see R12
			swd_active_o <= mode_reg == SWJ_MODE_SWD; // see R12 see R13
			power_up_req_o <= pwr_ok;
			bus_master_en_o <= pwr_ok && active_mode_i &&
				|(sel_hot & open_ap); // see R21
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			if (acc && !wb_we_i) begin
				wb_dat_o <= (wb_adr_i == `SWJ_OFF_CTRL) ?
					{25'h0, dis_reg, 1'b0, en_reg} :
					(wb_adr_i == `SWJ_OFF_STAT) ?
					{23'h0, ap_grant_o, 1'b0, pwr_ok, line_rst,
					tap_rst_reg, jtag_active_o, mode_reg} :
					32'h0000_0000;
			end
		end
	end
	// Packet replies are outside this block, so the line is never driven.
	assign link.dm_dev_out = 1'b0;
	assign link.dm_dev_oe = 1'b0;
endmodule : swj_device
`default_nettype wire

// file: swj_defs.svh
`ifndef SWJ_DEFS_SVH
`define SWJ_DEFS_SVH
`define SWJ_PAT_TO_SWD 16'h79E7
`define SWJ_PAT_TO_JTAG 16'h3CE7
`define SWJ_PAT_BITS 16
`define SWJ_LEAD_HIGH 50
`define SWJ_TRAIL_SWD 50
`define SWJ_TRAIL_JTAG 5
`define SWJ_LINE_RESET_HIGH 50
`define SWJ_TAP_RESET_HIGH 5
`define SWJ_LINK_PERIOD_NS 160
`define SWJ_CLK_PERIOD_NS 4
`define SWJ_HALF_DIV (`SWJ_LINK_PERIOD_NS / (2 * `SWJ_CLK_PERIOD_NS))
`define SWJ_OFF_CTRL 4'h0
`define SWJ_OFF_STAT 4'h4
`define SWJ_GATE_EN_LSB 0
`define SWJ_GATE_DIS_LSB 4
`define SWJ_HC_GO 0
`define SWJ_HC_TO_JTAG 1
`define SWJ_HC_DBG_PWR 2
`define SWJ_HC_SYS_PWR 3
`define SWJ_HS_BUSY 0
`define SWJ_HS_DONE 1
`endif

// file: swj_pkg.sv
package swj_pkg;
	typedef enum logic {
		SWJ_MODE_JTAG = 1'b0,
		SWJ_MODE_SWD = 1'b1
	} swj_mode_e;
	typedef enum logic [1:0] {
		SWJ_H_IDLE = 2'b00,
		SWJ_H_RUN = 2'b01
	} swj_hstate_e;
	typedef logic [2:0] swj_ap_t;
endpackage : swj_pkg

// file: swj_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface swj_link_if;
	logic debug_clock_pin;
	logic dm_host_out;
	logic dm_host_oe;
	logic dm_dev_out;
	logic dm_dev_oe;
	logic debug_data_mode_pin;
	logic debug_power_request;
	logic system_power_request;
	// Pull-up when nobody drives the data/mode line.
	assign debug_data_mode_pin = dm_host_oe ? dm_host_out :
		(dm_dev_oe ? dm_dev_out : 1'b1);
	modport host (output debug_clock_pin, output dm_host_out,
		output dm_host_oe, input debug_data_mode_pin,
		output debug_power_request, output system_power_request);
	modport device (input debug_clock_pin, output dm_dev_out,
		output dm_dev_oe, input debug_data_mode_pin,
		input debug_power_request, input system_power_request);
endinterface : swj_link_if
`default_nettype wire

// file: swj_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "swj_defs.svh"
module swj_host #(
	parameter int HALF_DIV = `SWJ_HALF_DIV,
	parameter int LEAD_HIGH = `SWJ_LEAD_HIGH,
	parameter int TRAIL_SWD = `SWJ_TRAIL_SWD,
	parameter int TRAIL_JTAG = `SWJ_TRAIL_JTAG
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	swj_link_if.host link
);
	import swj_pkg::*;
	swj_hstate_e state_reg;
	logic [7:0] div_reg;
	logic clk_reg;
	logic dm_reg;
	logic to_jtag_reg;
	logic dbg_pwr_reg;
	logic sys_pwr_reg;
	logic done_reg;
	logic [7:0] bit_reg;
	logic [7:0] total;
	logic [7:0] pat_idx;
	logic [15:0] pattern;
	logic next_bit;
	logic acc;
	logic wr_ctrl;
	logic wr_stat;
	logic go;
	logic div_hit;
	logic fall;
	logic last;
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctrl = acc && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == `SWJ_OFF_CTRL;
	assign wr_stat = acc && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == `SWJ_OFF_STAT;
	assign go = wr_ctrl && wb_dat_i[`SWJ_HC_GO] && state_reg == SWJ_H_IDLE;
	assign div_hit = div_reg == 8'(HALF_DIV - 1);
	assign fall = state_reg == SWJ_H_RUN && div_hit && clk_reg;
	assign total = 8'(LEAD_HIGH + `SWJ_PAT_BITS) +
		(to_jtag_reg ? 8'(TRAIL_JTAG) : 8'(TRAIL_SWD));
	assign last = bit_reg == total - 8'h01;
	assign pattern = to_jtag_reg ? `SWJ_PAT_TO_JTAG : `SWJ_PAT_TO_SWD;
	assign pat_idx = bit_reg + 8'h01 - 8'(LEAD_HIGH);
	// Lead highs, then the pattern MSb first, then trailing highs.
	assign next_bit = (bit_reg + 8'h01 < 8'(LEAD_HIGH) ||
		pat_idx >= 8'(`SWJ_PAT_BITS)) ? 1'b1 :
		pattern[4'(15 - pat_idx[3:0])]; // see R16 see R18 see R20
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= SWJ_H_IDLE;
			div_reg <= 8'h00;
			clk_reg <= 1'b0;
			dm_reg <= 1'b1;
			bit_reg <= 8'h00;
			done_reg <= 1'b0;
		end else begin
			div_reg <= (state_reg == SWJ_H_IDLE || div_hit) ? 8'h00 :
				div_reg + 8'h01;
			if (state_reg == SWJ_H_RUN && div_hit) begin
				clk_reg <= !clk_reg;
			end
			unique case (state_reg)
				SWJ_H_IDLE: begin
					if (go) begin
						state_reg <= SWJ_H_RUN;
						bit_reg <= 8'h00;
						dm_reg <= 1'b1;
					end
				end
				SWJ_H_RUN: begin
					// Data changes on the falling edge of the link clock.
					if (fall) begin
						bit_reg <= bit_reg + 8'h01;
						dm_reg <= last ? 1'b1 : next_bit;
						if (last) begin
							state_reg <= SWJ_H_IDLE;
						end
					end
				end
			endcase
			// A finishing sequence wins over a clear in the same cycle.
			if (fall && last) begin
				done_reg <= 1'b1;
			end else if (wr_stat && wb_dat_i[`SWJ_HS_DONE]) begin
				done_reg <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			to_jtag_reg <= 1'b0;
			dbg_pwr_reg <= 1'b0;
			sys_pwr_reg <= 1'b0;
		end else if (wr_ctrl) begin
			if (state_reg == SWJ_H_IDLE) begin
				to_jtag_reg <= wb_dat_i[`SWJ_HC_TO_JTAG];
			end
			dbg_pwr_reg <= wb_dat_i[`SWJ_HC_DBG_PWR]; // see R10 see R11
			sys_pwr_reg <= wb_dat_i[`SWJ_HC_SYS_PWR]; // see R10 see R11
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			if (acc && !wb_we_i) begin
				wb_dat_o <= (wb_adr_i == `SWJ_OFF_CTRL) ?
					{28'h0, sys_pwr_reg, dbg_pwr_reg, to_jtag_reg, 1'b0} :
					(wb_adr_i == `SWJ_OFF_STAT) ?
					{30'h0, done_reg, state_reg == SWJ_H_RUN} :
					32'h0000_0000;
			end
		end
	end
	assign link.debug_clock_pin = clk_reg;
	assign link.dm_host_out = dm_reg;
	assign link.dm_host_oe = 1'b1;
	assign link.debug_power_request = dbg_pwr_reg;
	assign link.system_power_request = sys_pwr_reg;
endmodule : swj_host
`default_nettype wire

// file: swj_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module swj_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic debug_clock_pin,
	input wire logic debug_power_request,
	input wire logic system_power_request,
	input wire logic active_mode_i,
	input wire logic [1:0] ap_sel_i,
	input wire swj_pkg::swj_ap_t ap_grant_o,
	input wire logic rom_table_sel_o,
	input wire logic jtag_active_o,
	input wire logic swd_active_o,
	input wire logic power_up_req_o
);
	import swj_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_grant_onehot: assert property ($onehot0(ap_grant_o))
		else $error("two ports granted");
	a_first_core_only: assert property (
		ap_grant_o[0] |-> $past(ap_sel_i) == 2'h0)
		else $error("first core grant without its select");
	a_second_core_only: assert property (
		ap_grant_o[1] |-> $past(ap_sel_i) == 2'h1)
		else $error("second core grant without its select");
	a_rom_system_only: assert property (
		rom_table_sel_o |-> $past(ap_sel_i) == 2'h2)
		else $error("rom table reached without system port");
	a_one_protocol: assert property (
		!(jtag_active_o && swd_active_o))
		else $error("both protocols active");
	a_sleep_no_jtag: assert property (
		!active_mode_i [*2] |-> !jtag_active_o)
		else $error("jtag active in deep sleep");
	a_mode_holds: assert property (
		!debug_clock_pin [*8] |=> $stable(swd_active_o))
		else $error("mode changed without link clock");
	a_power_grant: assert property (
		|ap_grant_o |-> power_up_req_o)
		else $error("grant without power requests");
	a_power_seen: assert property (
		(debug_power_request && system_power_request) [*6]
		|-> power_up_req_o)
		else $error("power requests not seen");
	a_clock_high_time: assert property (
		$rose(debug_clock_pin) |-> debug_clock_pin [*8])
		else $error("link clock high phase too short");
	c_to_swd: cover property ($rose(swd_active_o));
	c_to_jtag: cover property ($fell(swd_active_o));
	c_sys_port: cover property (rom_table_sel_o);
endmodule : swj_monitor
`default_nettype wire

// file: swj_debug_port_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module swj_debug_port_select_tb;
	import swj_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hc, dc, we, act, ha, da, rom, jt, sw, pw, bm;
	logic [3:0] adr;
	logic [31:0] wd, rd, hq, dq;
	logic [1:0] sel;
	swj_ap_t gnt;
	int error_cnt = 0;
	int cmp_count = 0;
	swj_link_if lk();
	always #2 clk_i = ~clk_i;
	swj_host i_swj_host(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(hc),
		.wb_stb_i(hc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wd), .wb_dat_o(hq), .wb_ack_o(ha), .link(lk.host));
	swj_device i_swj_device(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(dc),
		.wb_stb_i(dc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wd), .wb_dat_o(dq), .wb_ack_o(da), .ap_sel_i(sel),
		.active_mode_i(act), .ap_grant_o(gnt), .rom_table_sel_o(rom),
		.jtag_active_o(jt), .swd_active_o(sw), .power_up_req_o(pw),
		.bus_master_en_o(bm), .link(lk.device));
	swj_monitor i_swj_monitor(.clk_i(clk_i), .rst_i(rst_i),
		.debug_clock_pin(lk.debug_clock_pin),
		.debug_power_request(lk.debug_power_request),
		.system_power_request(lk.system_power_request),
		.active_mode_i(act), .ap_sel_i(sel), .ap_grant_o(gnt),
		.rom_table_sel_o(rom), .jtag_active_o(jt), .swd_active_o(sw),
		.power_up_req_o(pw));
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// The request stands until the edge at which ack is sampled high; the
	// read data is taken and the request released at that same edge.
	// Only the watchdog ends a wait for an ack that never comes.
	task automatic wb(input bit d, input bit w, input logic [3:0] a,
			input logic [31:0] v);
		@(posedge clk_i);
		adr <= a;
		we <= w;
		wd <= v;
		dc <= d;
		hc <= !d;
		do begin
			@(posedge clk_i);
		end while ((d ? da : ha) !== 1'b1);
		rd = d ? dq : hq;
		dc <= 1'b0;
		hc <= 1'b0;
	endtask : wb
	task automatic send(input logic [31:0] c);
		int n;
		n = 0;
		wb(0, 1, 4'h0, c);
		wb(0, 0, 4'h4, 32'h0);
		chk(rd[0], 1'b1);
		while (rd[1] !== 1'b1 && n < 2000) begin
			wb(0, 0, 4'h4, 32'h0);
			n++;
		end
		chk(rd[1], 1'b1);
		wb(0, 1, 4'h4, 32'h2);
		repeat (10) @(posedge clk_i);
	endtask : send
	task automatic gl(input logic [2:0] en);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			sel <= i[1:0];
			repeat (3) @(posedge clk_i);
			chk(gnt, (i < 3 && en[i]) ? 3'h1 << i : 3'h0);
			chk(rom, i == 2 && en[2]);
		end
	endtask : gl
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : do_reset
	initial begin
		repeat (40000) @(posedge clk_i);
		error_cnt++;
		complete_run();
	end
	initial begin
		{hc, dc, we, adr, wd} <= '0;
		sel <= 2'h3;
		act <= 1'b1;
		do_reset();
		chk(jt, 1'b1);
		chk(sw, 1'b0);
		wb(1, 0, 4'h0, 32'h0);
		chk(rd, 32'h0);
		wb(1, 0, 4'h8, 32'h0);
		chk(rd, 32'h0);
		// Both power requests stay set in every later control write.
		wb(0, 1, 4'h0, 32'hC);
		repeat (8) @(posedge clk_i);
		chk(pw, 1'b1);
		gl(3'h0);
		wb(1, 1, 4'h0, 32'h07);
		gl(3'h7);
		wb(1, 1, 4'h0, 32'h17);
		gl(3'h6);
		wb(1, 1, 4'h0, 32'h07);
		wb(1, 0, 4'h0, 32'h0);
		chk(rd, 32'h17);
		send(32'hF);
		chk(sw, 1'b0);
		send(32'hD);
		chk(sw, 1'b1);
		chk(jt, 1'b0);
		send(32'hD);
		chk(sw, 1'b1);
		send(32'hF);
		chk(jt, 1'b1);
		wb(1, 0, 4'h4, 32'h0);
		chk(rd[2:0], 3'h6);
		@(posedge clk_i);
		sel <= 2'h1;
		act <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(jt, 1'b0);
		chk(bm, 1'b0);
		act <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(bm, 1'b1);
		chk(pw, 1'b1);
		do_reset();
		wb(1, 0, 4'h0, 32'h0);
		chk(rd, 32'h0);
		complete_run();
	end
endmodule : swj_debug_port_select_tb
`default_nettype wire
